/* design/vosc_defines.vh */
// Constants of the video output status and control register bank.
// Assumes a 32-bit register port with byte addresses on word boundaries.
`ifndef VOSC_DEFINES_VH
`define VOSC_DEFINES_VH

// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define VOSC_ADDR_W          8
`define VOSC_OFS_CONTROL     8'h00
`define VOSC_OFS_STATUS      8'h04
`define VOSC_OFS_THRESHOLD   8'h08

// ---------------------------------------------------------------------
// Control word layout
// ---------------------------------------------------------------------
`define VOSC_CTL_RESET       32'h32400000
`define VOSC_CTL_STORE_MASK  32'hffe0ffff
`define VOSC_CTL_ENABLE      0
`define VOSC_CTL_MODE_HI     7
`define VOSC_CTL_MODE_LO     4
`define VOSC_CTL_IE_LO       8
`define VOSC_CTL_IE_HI       12
`define VOSC_CTL_ACK_LO      16
`define VOSC_CTL_ACK_HI      20

// ---------------------------------------------------------------------
// Flag vector indices; each flag has its enable and clear bit at the
// same index above the IE and ACK base positions.
// ---------------------------------------------------------------------
`define VOSC_NFLAGS          5
`define VOSC_FLG_FIRST       0
`define VOSC_FLG_SECOND      1
`define VOSC_FLG_UNDERRUN    2
`define VOSC_FLG_BANDWIDTH   3
`define VOSC_FLG_THRESHOLD   4

// ---------------------------------------------------------------------
// Status word layout
// ---------------------------------------------------------------------
`define VOSC_ST_FIRST        0
`define VOSC_ST_SECOND       1
`define VOSC_ST_UNDERRUN     2
`define VOSC_ST_THRESHOLD    3
`define VOSC_ST_UNIT         4
`define VOSC_ST_BANDWIDTH    5
`define VOSC_ST_FIELD2       6
`define VOSC_ST_VBLANK       7
`define VOSC_ST_PIXEL_LO     8
`define VOSC_ST_PIXEL_HI     19
`define VOSC_ST_LINE_LO      20
`define VOSC_ST_LINE_HI      31
`define VOSC_ST_RESERVED_LO  8'h00

// ---------------------------------------------------------------------
// Counters, threshold and operating modes
// ---------------------------------------------------------------------
`define VOSC_CNT_W           12
`define VOSC_SIZE_W          24
`define VOSC_THR_PAD         20'h00000
`define VOSC_MODE_RESERVED   4'h7
`define VOSC_MODE_STREAM     4'h8
`define VOSC_MODE_MESSAGE    4'h9

`endif

/* design/vosc_flag.v */
// One sticky status flag of the video output register bank.
// Assumes set and clear are single-cycle pulses on clk_sys.
`timescale 1ns/1ps

module vosc_flag (
   input  wire clk_sys,
   input  wire rst,
   input  wire set,
   input  wire clear,
   output reg  flag
);

   // -----------------------------------------------------------------
   // Flag storage
   // -----------------------------------------------------------------
   // A set in the same cycle as a clear wins, so no event is lost.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear) begin
         flag <= 1'b0;
      end
   end

endmodule // vosc_flag

/* design/vosc_status_control.v */
// Control and status register bank of the video output unit.
// Assumes a single-cycle register port and a datapath on clk_sys.
//
// Behaviour
// - Hardware reset loads control word 0x32400000.
// - Control word sets mode, enables, clears, start.
// - Image modes: line index shows live line.
// - Image modes: pixel index shows last pixel.
// - Stream modes: both fields form 24-bit byte count.
// - Refresh: first drained at overlap end.
// - Unacknowledged first at active video sets underrun.
// - Stream: drained at last byte, stops buffer.
// - Message mode: first drained at message end.
// - Each drained flag interrupts when enabled.
// - Late bus read with missing data flags bandwidth.
// - Bandwidth error sets in every transfer mode.
// - Unit-type bit always reads one.
// - Refresh: line equals threshold sets hit flag.
// - First acknowledge write clears first drained flag.
// - Refresh underrun keeps previous base pointers.
// - Stream underrun without acknowledge keeps old pointers.
// - Unit-type indicator sits at status bit 4.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "vosc_defines.vh"

module vosc_status_control (
   input  wire                     clk_sys,
   input  wire                     rst,
   input  wire [`VOSC_ADDR_W-1:0]  reg_addr,
   input  wire [31:0]              reg_wdata,
   input  wire                     reg_write,
   input  wire                     reg_read,
   output reg  [31:0]              reg_rdata,
   input  wire [`VOSC_CNT_W-1:0]   line_count,
   input  wire [`VOSC_CNT_W-1:0]   pixel_count,
   input  wire [`VOSC_SIZE_W-1:0]  size_count,
   input  wire                     field_second,
   input  wire                     vblank,
   input  wire                     overlap_done,
   input  wire                     active_video_start,
   input  wire                     first_buffer_done,
   input  wire                     second_buffer_done,
   input  wire                     message_done,
   input  wire                     bus_read_late,
   input  wire                     output_data_missing,
   output reg  [3:0]               video_mode,
   output reg                      unit_enable,
   output reg                      unit_start,
   output wire                     first_buffer_hold,
   output wire                     second_buffer_hold,
   output reg                      keep_previous_pointers,
   output reg                      irq_first_buffer,
   output reg                      irq_second_buffer,
   output reg                      irq_status
);

   // -----------------------------------------------------------------
   // Mode decoding
   // -----------------------------------------------------------------
   // Image (video-refresh) modes are every code below the reserved one.
   function is_image;
      input [3:0] mode;
      begin
         is_image = (mode < `VOSC_MODE_RESERVED);
      end
   endfunction

   function is_stream;
      input [3:0] mode;
      begin
         is_stream = (mode == `VOSC_MODE_STREAM);
      end
   endfunction

   function is_message;
      input [3:0] mode;
      begin
         is_message = (mode == `VOSC_MODE_MESSAGE);
      end
   endfunction

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   reg  [31:0]                 output_control_word;
   reg  [`VOSC_CNT_W-1:0]      line_threshold_register;
   reg                         threshold_match_q;
   reg  [31:0]                 output_status_word;
   reg  [`VOSC_CNT_W-1:0]      line_index;
   reg  [`VOSC_CNT_W-1:0]      pixel_index;
   reg  [`VOSC_NFLAGS-1:0]     flag_set;
   wire [`VOSC_NFLAGS-1:0]     flag_clear;
   wire [`VOSC_NFLAGS-1:0]     flags;
   wire [3:0]                  mode;
   wire                        enabled;
   wire                        mode_image;
   wire                        mode_stream;
   wire                        mode_message;
   wire                        ctl_write;
   wire                        thr_write;
   wire                        first_buffer_acknowledge;
   wire                        second_buffer_acknowledge;
   wire                        threshold_match;
   wire                        underrun_video;
   wire                        underrun_stream;
   wire [`VOSC_NFLAGS-1:0]     irq_enable;

   assign mode         = output_control_word[`VOSC_CTL_MODE_HI:
                                             `VOSC_CTL_MODE_LO];
   assign enabled      = output_control_word[`VOSC_CTL_ENABLE];
   assign mode_image   = is_image(mode);
   assign mode_stream  = is_stream(mode);
   assign mode_message = is_message(mode);
   assign irq_enable   = output_control_word[`VOSC_CTL_IE_HI:
                                             `VOSC_CTL_IE_LO];

   assign ctl_write = reg_write & (reg_addr == `VOSC_OFS_CONTROL);
   assign thr_write = reg_write & (reg_addr == `VOSC_OFS_THRESHOLD);

   // Acknowledge and clear bits act on the write and are never stored.
   assign flag_clear = ctl_write ?
                       reg_wdata[`VOSC_CTL_ACK_HI:`VOSC_CTL_ACK_LO] :
                       {`VOSC_NFLAGS{1'b0}};
   assign first_buffer_acknowledge  = flag_clear[`VOSC_FLG_FIRST];
   assign second_buffer_acknowledge = flag_clear[`VOSC_FLG_SECOND];

   // -----------------------------------------------------------------
   // Control word and threshold register
   // -----------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         output_control_word <= `VOSC_CTL_RESET;
      end else if (ctl_write) begin
         output_control_word <= reg_wdata & `VOSC_CTL_STORE_MASK;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         line_threshold_register <= {`VOSC_CNT_W{1'b0}};
      end else if (thr_write) begin
         line_threshold_register <= reg_wdata[`VOSC_CNT_W-1:0];
      end
   end

   // Copies for the datapath; the start pulse marks a write that turns
   // the unit on from off.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         video_mode  <= 4'h0;
         unit_enable <= 1'b0;
         unit_start  <= 1'b0;
      end else begin
         video_mode  <= mode;
         unit_enable <= enabled;
         unit_start  <= ctl_write & reg_wdata[`VOSC_CTL_ENABLE]
                        & ~enabled;
      end
   end

   // -----------------------------------------------------------------
   // Flag events
   // -----------------------------------------------------------------
   // The threshold flag fires on the cycle the line counter reaches the
   // threshold, so that clearing it on the same line does not re-raise.
   assign threshold_match = (line_count == line_threshold_register);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         threshold_match_q <= 1'b0;
      end else begin
         threshold_match_q <= threshold_match;
      end
   end

   // An acknowledge arriving together with the start of active video is
   // taken as in time.
   assign underrun_video  = enabled & mode_image & active_video_start
                            & flags[`VOSC_FLG_FIRST]
                            & ~first_buffer_acknowledge;
   assign underrun_stream = enabled & mode_stream &
                            ((first_buffer_done &
                              flags[`VOSC_FLG_SECOND] &
                              ~second_buffer_acknowledge) |
                             (second_buffer_done &
                              flags[`VOSC_FLG_FIRST] &
                              ~first_buffer_acknowledge));

   always @* begin
      flag_set = {`VOSC_NFLAGS{1'b0}};
      flag_set[`VOSC_FLG_FIRST] = enabled &
         ((mode_image & overlap_done) |
          (mode_stream & first_buffer_done) |
          (mode_message & message_done));
      flag_set[`VOSC_FLG_SECOND] = enabled & mode_stream
                                   & second_buffer_done;
      flag_set[`VOSC_FLG_UNDERRUN] = underrun_video | underrun_stream;
      // Any transfer mode may raise the bandwidth error.
      flag_set[`VOSC_FLG_BANDWIDTH] = enabled & bus_read_late
                                      & output_data_missing;
      flag_set[`VOSC_FLG_THRESHOLD] = enabled & mode_image
                                      & threshold_match
                                      & ~threshold_match_q;
   end

   // -----------------------------------------------------------------
   // Sticky flags
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `VOSC_NFLAGS; gi = gi + 1) begin : g_flag
         vosc_flag u_flag (
            .clk_sys (clk_sys),
            .rst     (rst),
            .set     (flag_set[gi]),
            .clear   (flag_clear[gi]),
            .flag    (flags[gi])
         );
      end
   endgenerate

   // A drained buffer gives no more data until it is acknowledged.
   assign first_buffer_hold  = flags[`VOSC_FLG_FIRST];
   assign second_buffer_hold = flags[`VOSC_FLG_SECOND];

   // On an underrun the datapath reuses the old pointers instead of
   // switching to pointers that software never confirmed.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         keep_previous_pointers <= 1'b0;
      end else begin
         keep_previous_pointers <= underrun_video
                                   | underrun_stream;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt requests
   // -----------------------------------------------------------------
   // Each buffer has a request line of its own, so one interrupt per
   // buffer is signalled.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_first_buffer  <= 1'b0;
         irq_second_buffer <= 1'b0;
         irq_status        <= 1'b0;
      end else begin
         irq_first_buffer  <= flags[`VOSC_FLG_FIRST]
                              & irq_enable[`VOSC_FLG_FIRST];
         irq_second_buffer <= flags[`VOSC_FLG_SECOND]
                              & irq_enable[`VOSC_FLG_SECOND];
         irq_status <= |(flags[`VOSC_NFLAGS-1:`VOSC_FLG_UNDERRUN]
                         & irq_enable[`VOSC_NFLAGS-1:`VOSC_FLG_UNDERRUN]);
      end
   end

   // -----------------------------------------------------------------
   // Status word
   // -----------------------------------------------------------------
   // In stream and message modes the two index fields carry the byte
   // counter; its two lowest bits move during transfers and are not
   // meaningful then.
   always @* begin
      if (mode_stream | mode_message) begin
         line_index  = size_count[`VOSC_SIZE_W-1:`VOSC_CNT_W];
         pixel_index = size_count[`VOSC_CNT_W-1:0];
      end else begin
         line_index  = line_count;
         pixel_index = pixel_count;
      end
   end

   always @* begin
      output_status_word = {24'h000000, `VOSC_ST_RESERVED_LO};
      output_status_word[`VOSC_ST_LINE_HI:`VOSC_ST_LINE_LO]   = line_index;
      output_status_word[`VOSC_ST_PIXEL_HI:`VOSC_ST_PIXEL_LO] = pixel_index;
      output_status_word[`VOSC_ST_FIRST]     = flags[`VOSC_FLG_FIRST];
      output_status_word[`VOSC_ST_SECOND]    = flags[`VOSC_FLG_SECOND];
      output_status_word[`VOSC_ST_UNDERRUN]  = flags[`VOSC_FLG_UNDERRUN];
      output_status_word[`VOSC_ST_THRESHOLD] = flags[`VOSC_FLG_THRESHOLD];
      output_status_word[`VOSC_ST_BANDWIDTH] = flags[`VOSC_FLG_BANDWIDTH];
      // Hard-wired so software can tell the enhanced unit apart.
      output_status_word[`VOSC_ST_UNIT]      = 1'b1;
      output_status_word[`VOSC_ST_FIELD2]    = field_second;
      // Vertical blanking is only meaningful while refreshing video.
      output_status_word[`VOSC_ST_VBLANK]    = vblank & mode_image;
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   // Read data stand for the one cycle after the strobe; unmapped
   // addresses and idle cycles read as zero.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_read) begin
         case (reg_addr)
            `VOSC_OFS_CONTROL: begin
               reg_rdata <= output_control_word;
            end
            `VOSC_OFS_STATUS: begin
               reg_rdata <= output_status_word;
            end
            `VOSC_OFS_THRESHOLD: begin
               reg_rdata <= {`VOSC_THR_PAD, line_threshold_register};
            end
            default: begin
               reg_rdata <= 32'h00000000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // vosc_status_control

/* tb/tb.sv */
// Self-checking bench for the video output status and control bank.
// Assumes the design's single clock and the one-cycle register port.
`timescale 1ns/1ps
`include "vosc_defines.vh"

module tb;
   localparam [31:0] CTL_IMG = 32'h32401f01;
   localparam [7:0] A_CTL = `VOSC_OFS_CONTROL, A_ST = `VOSC_OFS_STATUS;
   reg                      clk_sys = 1'b0;
   reg                      rst = 1'b1;
   reg  [`VOSC_ADDR_W-1:0]  reg_addr = 8'h00;
   reg  [31:0]              reg_wdata = 32'h0;
   reg                      reg_write = 1'b0;
   reg                      reg_read = 1'b0;
   wire [31:0]              reg_rdata;
   reg  [11:0]              line_count = 12'h000;
   reg  [11:0]              pixel_count = 12'h000;
   reg  [23:0]              size_count = 24'h000000;
   reg                      field_second = 1'b0;
   reg                      vblank = 1'b0;
   // Event pulses: overlap, active start, first, second, message, late, miss.
   reg  [6:0]               ev = 7'h00;
   wire [3:0]               video_mode;
   wire                     unit_enable, unit_start, first_buffer_hold;
   wire                     second_buffer_hold, keep_previous_pointers;
   wire                     irq_first_buffer, irq_second_buffer, irq_status;
   reg                      start_seen = 1'b0;
   integer                  kpp_n = 0, kpp_b = 0;
   reg  [31:0]              d;
   integer                  bad_count = 0;
   integer                  check_count = 0;

   always #5 clk_sys = ~clk_sys;

   // The start pulse is latched and keep-pointer pulses are counted between checks.
   always @(posedge clk_sys) begin
      if (!rst) begin
         start_seen <= start_seen | unit_start;
         kpp_n <= kpp_n + keep_previous_pointers;
      end
   end

   vosc_status_control DUT (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .line_count(line_count),
      .pixel_count(pixel_count), .size_count(size_count),
      .field_second(field_second), .vblank(vblank), .overlap_done(ev[0]),
      .active_video_start(ev[1]), .first_buffer_done(ev[2]),
      .second_buffer_done(ev[3]), .message_done(ev[4]),
      .bus_read_late(ev[5]), .output_data_missing(ev[6]),
      .video_mode(video_mode), .unit_enable(unit_enable),
      .unit_start(unit_start), .first_buffer_hold(first_buffer_hold),
      .second_buffer_hold(second_buffer_hold),
      .keep_previous_pointers(keep_previous_pointers),
      .irq_first_buffer(irq_first_buffer),
      .irq_second_buffer(irq_second_buffer), .irq_status(irq_status)
   );

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= v;
         reg_write <= 1'b1;
         @(posedge clk_sys);
         reg_write <= 1'b0;
      end
   endtask

   task rd(input [7:0] a);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clk_sys);
         reg_read <= 1'b0;
         #1;
         d = reg_rdata;
      end
   endtask

   task fire(input [6:0] m);
      begin
         @(posedge clk_sys);
         ev <= m;
         @(posedge clk_sys);
         ev <= 7'h00;
         #1;
      end
   endtask

   task wait2;
      begin
         repeat (2) @(posedge clk_sys);
         #1;
      end
   endtask

   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, bad_count);
         if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A_CTL);
      chk(d, 32'h32400000);
      rd(A_ST);
      chk(d[5:0], 6'h10);
      rd(8'h0c);
      chk(d, 32'h0);
      wr(A_CTL, 32'h5a5a5a50);
      rd(A_CTL);
      chk(d, 32'h5a405a50);
      wr(A_CTL, CTL_IMG);
      wait2;
      chk({start_seen, unit_enable, video_mode}, 6'h30);
      @(posedge clk_sys);
      line_count <= 12'h123;
      pixel_count <= 12'h456;
      vblank <= 1'b1;
      field_second <= 1'b1;
      rd(A_ST);
      chk(d[31:6], {24'h123456, 2'b11});
      // Refresh: field unacknowledged, then acknowledged.
      fire(7'h01);
      chk(first_buffer_hold, 1'b1);
      @(posedge clk_sys);
      #1;
      chk(irq_first_buffer, 1'b1);
      kpp_b = kpp_n;
      fire(7'h02);
      wait2;
      chk({kpp_n != kpp_b, first_buffer_hold}, 2'b11);
      rd(A_ST);
      chk(d[2:0], 3'b101);
      wr(A_CTL, CTL_IMG | 32'h00050000);
      #1;
      chk(first_buffer_hold, 1'b0);
      fire(7'h01);
      wr(A_CTL, CTL_IMG | 32'h00010000);
      kpp_b = kpp_n;
      fire(7'h02);
      wait2;
      chk({kpp_n != kpp_b, irq_first_buffer}, 2'b00);
      // Threshold hit fires once per match.
      wr(`VOSC_OFS_THRESHOLD, 32'h00000005);
      @(posedge clk_sys);
      line_count <= 12'h005;
      wait2;
      chk(irq_status, 1'b1);
      rd(A_ST);
      chk(d[3], 1'b1);
      wr(A_CTL, CTL_IMG | 32'h00100000);
      rd(A_ST);
      chk(d[3], 1'b0);
      fire(7'h20);
      rd(A_ST);
      chk(d[5:4], 2'b01);
      fire(7'h60);
      rd(A_ST);
      chk(d[5:4], 2'b11);
      wr(A_CTL, CTL_IMG | 32'h00080000);
      rd(A_ST);
      chk(d[5:4], 2'b01);
      // Streaming: both buffers drain, first still unacked.
      wr(A_CTL, 32'h325f1f81);
      @(posedge clk_sys);
      size_count <= 24'habcdef;
      rd(A_ST);
      chk(d[31:8], 24'habcdef);
      fire(7'h04);
      chk({first_buffer_hold, second_buffer_hold}, 2'b10);
      kpp_b = kpp_n;
      fire(7'h08);
      wait2;
      chk(second_buffer_hold, 1'b1);
      chk({kpp_n != kpp_b, irq_second_buffer}, 2'b11);
      fire(7'h60);
      rd(A_ST);
      chk({d[5], d[2:0]}, 4'hf);
      wr(A_CTL, 32'h325f1f91);
      fire(7'h10);
      chk(first_buffer_hold, 1'b1);
      summarize;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count = bad_count + 1;
      summarize;
   end
endmodule // tb

/* tb/vosc_status_control_properties.sv */
// Concurrent checks for the video output register bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "vosc_defines.vh"

module vosc_status_control_checker (
   input logic                     clk_sys,
   input logic                     rst,
   input logic [`VOSC_ADDR_W-1:0]  reg_addr,
   input logic [31:0]              reg_wdata,
   input logic                     reg_write,
   input logic                     reg_read,
   input logic [31:0]              reg_rdata,
   input logic [`VOSC_CNT_W-1:0]   line_count,
   input logic [`VOSC_CNT_W-1:0]   pixel_count,
   input logic [`VOSC_SIZE_W-1:0]  size_count,
   input logic                     overlap_done,
   input logic                     active_video_start,
   input logic                     first_buffer_done,
   input logic                     second_buffer_done,
   input logic                     message_done,
   input logic [3:0]               video_mode,
   input logic                     unit_enable,
   input logic                     first_buffer_hold,
   input logic                     second_buffer_hold,
   input logic                     keep_previous_pointers,
   input logic                     irq_first_buffer,
   input logic                     irq_second_buffer
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   // Shadow of the stored control bits.
   logic [31:0] last_ctl;
   wire         ctl_wr = reg_write && reg_addr == `VOSC_OFS_CONTROL;
   wire         st_rd  = reg_read && reg_addr == `VOSC_OFS_STATUS;
   wire         img    = unit_enable && video_mode <= 4'h6;
   wire         strm   = unit_enable && video_mode == 4'h8;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         last_ctl <= `VOSC_CTL_RESET;
      end else if (ctl_wr) begin
         last_ctl <= reg_wdata & `VOSC_CTL_STORE_MASK;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_rdata_idle;
      !reg_read |=> reg_rdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
   property p_ctl_read;
      reg_read && reg_addr == `VOSC_OFS_CONTROL |=> reg_rdata == last_ctl;
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback");
   property p_status_flags;
      st_rd |=> reg_rdata[4] && reg_rdata[0] == $past(first_buffer_hold)
                && reg_rdata[1] == $past(second_buffer_hold);
   endproperty
   a_status_flags: assert property (p_status_flags) else $error("status flags");
   property p_img_counts;
      st_rd && video_mode <= 4'h6 && !$past(reg_write)
         |=> reg_rdata[31:8] == {$past(line_count), $past(pixel_count)};
   endproperty
   a_img_counts: assert property (p_img_counts) else $error("index fields");
   property p_byte_count;
      st_rd && video_mode[3:1] == 3'b100 && !$past(reg_write)
         |=> reg_rdata[31:8] == $past(size_count);
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("byte count");
   property p_first_set;
      !$past(reg_write) && ((img && overlap_done)
         || (strm && first_buffer_done)
         || (unit_enable && video_mode == 4'h9 && message_done))
         |=> first_buffer_hold ##1 first_buffer_hold;
   endproperty
   a_first_set: assert property (p_first_set) else $error("first flag");
   property p_second_set;
      !$past(reg_write) && strm && second_buffer_done |=> second_buffer_hold;
   endproperty
   a_second_set: assert property (p_second_set) else $error("second flag");
   property p_ack_clear;
      ctl_wr && reg_wdata[16] && !overlap_done && !first_buffer_done
         && !message_done |=> !first_buffer_hold;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack clear");
   property p_irq_flag;
      (irq_first_buffer -> $past(first_buffer_hold))
         && (irq_second_buffer -> $past(second_buffer_hold));
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");
   property p_img_underrun_flag;
      img && !$past(reg_write) && active_video_start && first_buffer_hold
         && !reg_write |=> keep_previous_pointers;
   endproperty
   a_img_underrun_flag: assert property (p_img_underrun_flag) else $error("refresh underrun");
   property p_strm_underrun_flag;
      strm && !$past(reg_write) && !reg_write
         && second_buffer_done && first_buffer_hold |=> keep_previous_pointers;
   endproperty
   a_strm_underrun_flag: assert property (p_strm_underrun_flag) else $error("stream underrun");

   c_first: cover property (img && overlap_done ##1 first_buffer_hold);
   c_underrun_flag: cover property (keep_previous_pointers);
   c_second: cover property (irq_second_buffer);
endmodule // vosc_status_control_checker

bind vosc_status_control vosc_status_control_checker u_checker (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .line_count(line_count), .pixel_count(pixel_count),
   .size_count(size_count), .overlap_done(overlap_done),
   .active_video_start(active_video_start),
   .first_buffer_done(first_buffer_done),
   .second_buffer_done(second_buffer_done), .message_done(message_done),
   .video_mode(video_mode), .unit_enable(unit_enable),
   .first_buffer_hold(first_buffer_hold),
   .second_buffer_hold(second_buffer_hold),
   .keep_previous_pointers(keep_previous_pointers),
   .irq_first_buffer(irq_first_buffer), .irq_second_buffer(irq_second_buffer)
);
